// File: hw/edg_seq.sv
// external diagnostic sequencer with its register slave
//
// Functional notes
// - hold while access-disable or shut-up active
// - shut-up latched, cleared only by board reset
// - no wake message: start ten-second timeout
// - memory updates allowed during wake wait
// - wake timeout pauses on shut-up or disable
// - timeout: non-fatal error, skip external tests
// - receive lamp off when wake phase ends
// - bus read checks only after wake; fatal
// - ring checks only after wake; fatal
// - bad check reply: protect lamp flashes six
// - after check passes, send queued errors
// - audio only after wake; converters first, non-fatal
// - audio errors sent at once, not queued
// - two-second disable watch freezes test conditions
// - four seconds after each failed audio test
// - alert tone absent enabled or present disabled
// - modulator tone: ungated absent, gated present
// - receive tone: gated present, ungated absent
// - version, latches, parameters, then interrupts enabled
// - transmit lamp off, then wait background enable
// - no wake: start background immediately
// - protect lamp off before background starts
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module edg_seq #(
  parameter int TICK_CYCLES = edg_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins from the station
  input wire logic access_disable_pin,
  input wire logic tone_detect_pin,
  input wire logic station_reset_pin,
  // interprocessor bus messages
  input wire edg_pkg::edg_msg_type ipb_rx,
  output edg_pkg::edg_msg_type ipb_tx,
  input wire logic ipb_tx_ack,
  // external check engine
  output logic diag_req,
  output logic [1:0] diag_sel,
  input wire logic diag_done,
  input wire logic diag_pass,
  // audio path controls
  output edg_pkg::edg_aud_type aud_ctrl,
  // lamps and module enables
  output logic receive_activity_lamp,
  output logic transmit_activity_lamp,
  output logic protect_fail_lamp,
  output logic nvm_update_enable,
  output logic latch_init,
  output logic param_load,
  output logic rx_irq_enable,
  output logic tx_irq_enable,
  output logic background_run
);

  edg_pkg::edg_state_type state;
  edg_pkg::edg_state_type ret_state;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic reset_seen;
  logic station_reset;
  logic acc_dis;
  logic tone_present;
  logic [15:0] pre;
  logic tick;
  logic [13:0] tmr;
  logic tmr_run;
  logic shutup;
  logic wake_seen;
  logic ipb_fail;
  logic frozen;
  logic [3:0] flash_cnt;
  logic [2:0] step;
  logic [7:0] queue [8];
  logic [2:0] q_wr;
  logic [2:0] q_rd;
  logic [3:0] q_count;
  logic err_log;
  logic [7:0] err_code;
  logic [7:0] last_err;
  logic [7:0] fatal_cnt;
  logic [7:0] nonfatal_cnt;
  logic ctrl_start;
  logic [7:0] version;
  logic rx_wake;

  // audio step table: steps 1..6 drive the paths, step 0 is the converter check
  function automatic edg_pkg::edg_aud_type aud_cfg(input logic [2:0] s);
    edg_pkg::edg_aud_type c;
    c = '0;
    case (s)
      3'h1: c.alert_tone_en = '1;
      3'h3: c.mod_tone_en = '1;
      3'h4: begin
        c.mod_tone_en = '1;
        c.mod_tone_gate = '1;
      end
      3'h5: begin
        c.end_of_message_tone = '1;
        c.ciphered_audio_gate = '1;
      end
      3'h6: c.end_of_message_tone = '1;
      default: c = '0;
    endcase
    return c;
  endfunction

  // tone that a healthy path shows in each step
  function automatic logic aud_expect(input logic [2:0] s);
    return (s == 3'h1) || (s == 3'h4) || (s == 3'h5);
  endfunction

  // register decode shared by reads and writes; 3'h7 means unmapped
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    case (a)
      edg_pkg::REG_CTRL: return 3'h0;
      edg_pkg::REG_STATUS: return 3'h1;
      edg_pkg::REG_ERRORS: return 3'h2;
      edg_pkg::REG_VERSION: return 3'h3;
      edg_pkg::REG_TIMER: return 3'h4;
      default: return 3'h7;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops each before anything looks at them
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          sync_a[gi] <= '0;
          sync_b[gi] <= '0;
        end else begin
          sync_a[gi] <= gi == 0 ? access_disable_pin : (gi == 1 ? tone_detect_pin : station_reset_pin);
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate
  assign acc_dis = sync_b[0];
  assign tone_present = sync_b[1];

  // the station reset acts on its rising edge only, so a held switch restarts once
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reset_seen <= '0;
    end else begin
      reset_seen <= sync_b[2];
    end
  end
  assign station_reset = sync_b[2] && !reset_seen;
  assign rx_wake = ipb_rx.valid && ipb_rx.kind == edg_pkg::MSG_WAKE;

  ////////////////////////////////////////////////////////////////////////////
  // millisecond prescaler feeding every timeout
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre <= '0;
    end else if (pre == 16'(TICK_CYCLES - 1)) begin
      pre <= '0;
    end else begin
      pre <= pre + 16'h0001;
    end
  end
  assign tick = pre == 16'(TICK_CYCLES - 1);

  // the wake wait halts rather than restarts, so an update does not eat it
  assign tmr_run = !(state == edg_pkg::ST_WAKE && (acc_dis || shutup));

  // shut-up survives everything but a reset from the control board; arrival wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shutup <= '0;
    end else if (ipb_rx.valid && ipb_rx.kind == edg_pkg::MSG_SHUTUP) begin
      shutup <= '1;
    end else if (station_reset) begin
      shutup <= '0;
    end
  end

  // memory updates are only safe while waiting for the wake message
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nvm_update_enable <= '0;
    end else begin
      nvm_update_enable <= state == edg_pkg::ST_WAKE;
    end
  end

  // error statistics seen by software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_err <= '0;
      fatal_cnt <= '0;
      nonfatal_cnt <= '0;
    end else if (err_log) begin
      last_err <= err_code;
      if (err_code[7]) begin
        fatal_cnt <= fatal_cnt + 8'h01;
      end else begin
        nonfatal_cnt <= nonfatal_cnt + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= edg_pkg::ST_IDLE;
      ret_state <= edg_pkg::ST_IDLE;
      tmr <= '0;
      wake_seen <= '0;
      ipb_fail <= '0;
      frozen <= '0;
      flash_cnt <= '0;
      step <= '0;
      q_wr <= '0;
      q_rd <= '0;
      q_count <= '0;
      err_log <= '0;
      err_code <= '0;
      ipb_tx <= '0;
      diag_req <= '0;
      diag_sel <= '0;
      aud_ctrl <= '0;
      receive_activity_lamp <= '0;
      transmit_activity_lamp <= '0;
      protect_fail_lamp <= '0;
      latch_init <= '0;
      param_load <= '0;
      rx_irq_enable <= '0;
      tx_irq_enable <= '0;
      background_run <= '0;
    end else begin
      diag_req <= '0;
      err_log <= '0;
      latch_init <= '0;
      param_load <= '0;
      if (tick && tmr_run) begin
        tmr <= tmr + 14'h0001;
      end
      if (station_reset) begin
        // a control board reset restarts the whole sequence from idle
        state <= edg_pkg::ST_IDLE;
        wake_seen <= '0;
        ipb_fail <= '0;
        frozen <= '0;
        q_count <= '0;
        q_rd <= '0;
        q_wr <= '0;
        ipb_tx <= '0;
        aud_ctrl <= '0;
        rx_irq_enable <= '0;
        tx_irq_enable <= '0;
        background_run <= '0;
      end else begin
        case (state)
          edg_pkg::ST_IDLE: begin
            if (ctrl_start) begin
              receive_activity_lamp <= '1;
              transmit_activity_lamp <= '1;
              protect_fail_lamp <= '1;
              state <= edg_pkg::ST_HOLD;
            end
          end
          edg_pkg::ST_HOLD: begin
            if (rx_wake) begin
              wake_seen <= '1;
            end
            if (!acc_dis && !shutup) begin
              tmr <= '0;
              state <= edg_pkg::ST_WAKE;
            end
          end
          edg_pkg::ST_WAKE: begin
            if (wake_seen || rx_wake) begin
              wake_seen <= '1;
              receive_activity_lamp <= '0;
              diag_req <= '1;
              diag_sel <= edg_pkg::DIAG_MUX;
              state <= edg_pkg::ST_DIAG_WAIT;
            end else if (tmr >= edg_pkg::WAKE_TIMEOUT_MS) begin
              err_log <= '1;
              err_code <= edg_pkg::ERR_WAKE_TIMEOUT;
              queue[q_wr] <= edg_pkg::ERR_WAKE_TIMEOUT;
              q_wr <= q_wr + 3'h1;
              q_count <= q_count + 4'h1;
              receive_activity_lamp <= '0;
              ipb_tx <= '{!ipb_fail, edg_pkg::MSG_VERSION, version};
              ret_state <= edg_pkg::ST_ENABLE;
              step <= '0;
              state <= edg_pkg::ST_SEND;
            end
          end
          edg_pkg::ST_DIAG_WAIT: begin
            if (diag_done) begin
              case (diag_sel)
                edg_pkg::DIAG_MUX: begin
                  if (!diag_pass) begin
                    err_log <= '1;
                    err_code <= edg_pkg::ERR_MUX;
                    queue[q_wr] <= edg_pkg::ERR_MUX;
                    q_wr <= q_wr + 3'h1;
                    q_count <= q_count + 4'h1;
                  end
                  diag_req <= '1;
                  diag_sel <= edg_pkg::DIAG_RING;
                end
                edg_pkg::DIAG_RING: begin
                  if (!diag_pass) begin
                    err_log <= '1;
                    err_code <= edg_pkg::ERR_RING;
                    queue[q_wr] <= edg_pkg::ERR_RING;
                    q_wr <= q_wr + 3'h1;
                    q_count <= q_count + 4'h1;
                  end
                  ipb_tx <= '{'1, edg_pkg::MSG_CHECK, edg_pkg::CHECK_PATTERN};
                  ret_state <= edg_pkg::ST_IPB_WAIT;
                  state <= edg_pkg::ST_SEND;
                end
                default: begin
                  if (!diag_pass) begin
                    err_log <= '1;
                    err_code <= edg_pkg::ERR_AUDIO_BASE;
                    ipb_tx <= '{!ipb_fail, edg_pkg::MSG_ERROR, edg_pkg::ERR_AUDIO_BASE};
                    ret_state <= edg_pkg::ST_AUD_WATCH;
                    state <= edg_pkg::ST_SEND;
                  end else begin
                    state <= edg_pkg::ST_AUD_NEXT;
                  end
                end
              endcase
            end
          end
          edg_pkg::ST_SEND: begin
            // a failed bus check turns every later send into a no-op
            if (!ipb_tx.valid || ipb_tx_ack) begin
              ipb_tx.valid <= '0;
              tmr <= '0;
              state <= ret_state;
            end
          end
          edg_pkg::ST_IPB_WAIT: begin
            if (ipb_rx.valid && ipb_rx.kind == edg_pkg::MSG_CHECK_REPLY) begin
              if (ipb_rx.data == edg_pkg::CHECK_ANSWER) begin
                state <= edg_pkg::ST_DRAIN;
              end else begin
                ipb_fail <= '1;
                protect_fail_lamp <= '0;
                flash_cnt <= '0;
                tmr <= '0;
                state <= edg_pkg::ST_FLASH;
              end
            end else if (tmr >= edg_pkg::IPB_REPLY_MS) begin
              ipb_fail <= '1;
              protect_fail_lamp <= '0;
              flash_cnt <= '0;
              tmr <= '0;
              state <= edg_pkg::ST_FLASH;
            end
          end
          edg_pkg::ST_FLASH: begin
            if (tmr >= edg_pkg::FLASH_HALF_MS) begin
              tmr <= '0;
              flash_cnt <= flash_cnt + 4'h1;
              protect_fail_lamp <= !protect_fail_lamp;
              if (flash_cnt == edg_pkg::FLASH_TOGGLES - 4'h1) begin
                protect_fail_lamp <= '1;
                state <= edg_pkg::ST_DRAIN;
              end
            end
          end
          edg_pkg::ST_DRAIN: begin
            if (q_count != 4'h0) begin
              ipb_tx <= '{!ipb_fail, edg_pkg::MSG_ERROR, queue[q_rd]};
              q_rd <= q_rd + 3'h1;
              q_count <= q_count - 4'h1;
              ret_state <= edg_pkg::ST_DRAIN;
              state <= edg_pkg::ST_SEND;
            end else begin
              step <= '0;
              diag_req <= '1;
              diag_sel <= edg_pkg::DIAG_ADC;
              state <= edg_pkg::ST_DIAG_WAIT;
            end
          end
          edg_pkg::ST_AUD_SAMPLE: begin
            if (tmr >= edg_pkg::AUD_SETTLE_MS) begin
              if (tone_present != aud_expect(step)) begin
                err_log <= '1;
                err_code <= edg_pkg::ERR_AUDIO_BASE + {5'h00, step};
                ipb_tx <= '{!ipb_fail, edg_pkg::MSG_ERROR, edg_pkg::ERR_AUDIO_BASE + {5'h00, step}};
                ret_state <= edg_pkg::ST_AUD_WATCH;
                state <= edg_pkg::ST_SEND;
              end else begin
                state <= edg_pkg::ST_AUD_NEXT;
              end
            end
          end
          edg_pkg::ST_AUD_WATCH: begin
            if (tmr < edg_pkg::FREEZE_WINDOW_MS && acc_dis) begin
              frozen <= '1;
              state <= edg_pkg::ST_FREEZE;
            end else if (tmr >= edg_pkg::AUD_FAIL_HOLD_MS) begin
              state <= edg_pkg::ST_AUD_NEXT;
            end
          end
          edg_pkg::ST_AUD_NEXT: begin
            if (step == edg_pkg::AUD_LAST_STEP) begin
              aud_ctrl <= '0;
              ipb_tx <= '{!ipb_fail, edg_pkg::MSG_VERSION, version};
              ret_state <= edg_pkg::ST_ENABLE;
              step <= '0;
              state <= edg_pkg::ST_SEND;
            end else begin
              aud_ctrl <= aud_cfg(step + 3'h1);
              step <= step + 3'h1;
              tmr <= '0;
              state <= edg_pkg::ST_AUD_SAMPLE;
            end
          end
          edg_pkg::ST_FREEZE: begin
            // paths stay as they were so the failed circuit can be probed
            state <= edg_pkg::ST_FREEZE;
          end
          edg_pkg::ST_ENABLE: begin
            step <= step + 3'h1;
            case (step)
              3'h0: latch_init <= '1;
              3'h1: param_load <= '1;
              3'h2: begin
                rx_irq_enable <= '1;
                tx_irq_enable <= '1;
              end
              default: begin
                transmit_activity_lamp <= '0;
                if (wake_seen) begin
                  state <= edg_pkg::ST_WAIT_BG;
                end else begin
                  protect_fail_lamp <= '0;
                  background_run <= '1;
                  state <= edg_pkg::ST_RUN;
                end
              end
            endcase
          end
          edg_pkg::ST_WAIT_BG: begin
            // no timeout here: other boards may still be testing
            if (ipb_rx.valid && ipb_rx.kind == edg_pkg::MSG_BG_ENABLE) begin
              protect_fail_lamp <= '0;
              background_run <= '1;
              state <= edg_pkg::ST_RUN;
            end
          end
          edg_pkg::ST_RUN: state <= edg_pkg::ST_RUN;
          default: state <= edg_pkg::ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register slave, write side: address and data are taken together
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= '0;
      s_axi_wready <= '0;
      s_axi_bvalid <= '0;
      s_axi_bresp <= '0;
      ctrl_start <= '0;
      version <= edg_pkg::VERSION_RESET;
    end else begin
      ctrl_start <= '0;
      s_axi_awready <= '0;
      s_axi_wready <= '0;
      if (s_axi_awready && s_axi_awvalid) begin
        s_axi_bvalid <= '1;
        s_axi_bresp <= reg_sel(s_axi_awaddr) == 3'h7 ? edg_pkg::RESP_SLVERR : edg_pkg::RESP_OKAY;
        if (reg_sel(s_axi_awaddr) == 3'h0 && s_axi_wstrb[0]) begin
          ctrl_start <= s_axi_wdata[0];
        end
        if (reg_sel(s_axi_awaddr) == 3'h3 && s_axi_wstrb[0]) begin
          version <= s_axi_wdata[7:0];
        end
      end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= '1;
        s_axi_wready <= '1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= '0;
      end
    end
  end

  // register slave, read side
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= '0;
      s_axi_rvalid <= '0;
      s_axi_rdata <= '0;
      s_axi_rresp <= '0;
    end else begin
      s_axi_arready <= '0;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= '1;
        s_axi_rresp <= reg_sel(s_axi_araddr) == 3'h7 ? edg_pkg::RESP_SLVERR : edg_pkg::RESP_OKAY;
        case (reg_sel(s_axi_araddr))
          3'h1: s_axi_rdata <= {12'h000, background_run, frozen, ipb_fail, shutup, wake_seen, state};
          3'h2: s_axi_rdata <= {8'h00, nonfatal_cnt, fatal_cnt, last_err};
          3'h3: s_axi_rdata <= {24'h00_0000, version};
          3'h4: s_axi_rdata <= {18'h0_0000, tmr};
          default: s_axi_rdata <= '0;
        endcase
      end else if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= '1;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= '0;
      end
    end
  end

endmodule

`default_nettype wire

// File: hw/edg_pkg.sv
// shared constants and types for the external diagnostic sequencer
package edg_pkg;

  // clock and the millisecond tick that every long wait counts in
  localparam int CLK_PERIOD_PS = 25000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_US * 1000000 / CLK_PERIOD_PS;

  // waits, in milliseconds, and the flash toggle count
  localparam logic [13:0] WAKE_TIMEOUT_MS = 14'h2710;
  localparam logic [13:0] FREEZE_WINDOW_MS = 14'h07d0;
  localparam logic [13:0] AUD_FAIL_HOLD_MS = 14'h0fa0;
  localparam logic [13:0] AUD_SETTLE_MS = 14'h0032;
  localparam logic [13:0] IPB_REPLY_MS = 14'h0064;
  localparam logic [13:0] FLASH_HALF_MS = 14'h00fa;
  localparam logic [3:0] FLASH_TOGGLES = 4'hc;

  // register byte offsets, version reset value and response codes
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ERRORS = 8'h08;
  localparam logic [7:0] REG_VERSION = 8'h0c;
  localparam logic [7:0] REG_TIMER = 8'h10;
  localparam logic [7:0] VERSION_RESET = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // interprocessor bus message kinds and check pattern
  localparam logic [3:0] MSG_WAKE = 4'h1;
  localparam logic [3:0] MSG_SHUTUP = 4'h2;
  localparam logic [3:0] MSG_BG_ENABLE = 4'h3;
  localparam logic [3:0] MSG_CHECK = 4'h4;
  localparam logic [3:0] MSG_CHECK_REPLY = 4'h5;
  localparam logic [3:0] MSG_ERROR = 4'h6;
  localparam logic [3:0] MSG_VERSION = 4'h7;
  localparam logic [7:0] CHECK_PATTERN = 8'ha5;
  localparam logic [7:0] CHECK_ANSWER = 8'h5a;

  // error codes, bit 7 marks a fatal one
  localparam logic [7:0] ERR_WAKE_TIMEOUT = 8'h01;
  localparam logic [7:0] ERR_MUX = 8'h81;
  localparam logic [7:0] ERR_RING = 8'h82;
  localparam logic [7:0] ERR_AUDIO_BASE = 8'h10;

  // external diagnostic engine selections and audio steps
  localparam logic [1:0] DIAG_MUX = 2'h0;
  localparam logic [1:0] DIAG_RING = 2'h1;
  localparam logic [1:0] DIAG_ADC = 2'h2;
  localparam logic [2:0] AUD_LAST_STEP = 3'h6;

  typedef struct packed {
    logic valid;
    logic [3:0] kind;
    logic [7:0] data;
  } edg_msg_type;

  typedef struct packed {
    logic alert_tone_en;
    logic mod_tone_en;
    logic mod_tone_gate;
    logic end_of_message_tone;
    logic ciphered_audio_gate;
  } edg_aud_type;

  typedef enum logic [14:0] {
    ST_IDLE = 15'h0001,
    ST_HOLD = 15'h0002,
    ST_WAKE = 15'h0004,
    ST_DIAG_WAIT = 15'h0008,
    ST_SEND = 15'h0010,
    ST_IPB_WAIT = 15'h0020,
    ST_FLASH = 15'h0040,
    ST_DRAIN = 15'h0080,
    ST_AUD_SAMPLE = 15'h0100,
    ST_AUD_WATCH = 15'h0200,
    ST_AUD_NEXT = 15'h0400,
    ST_FREEZE = 15'h0800,
    ST_ENABLE = 15'h1000,
    ST_WAIT_BG = 15'h2000,
    ST_RUN = 15'h4000
  } edg_state_type;

endpackage

// File: verification/edg_seq_sva.sv
// concurrent checks on the sequencer outputs
`timescale 1ns/1ps
`default_nettype none
module edg_seq_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // sequencer outputs and the message acknowledge
  input wire edg_pkg::edg_msg_type ipb_tx,
  input wire logic ipb_tx_ack,
  input wire logic diag_req,
  input wire logic receive_activity_lamp,
  input wire logic transmit_activity_lamp,
  input wire logic protect_fail_lamp,
  input wire logic latch_init,
  input wire logic param_load,
  input wire logic rx_irq_enable,
  input wire logic tx_irq_enable,
  input wire logic background_run
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_param_after_latch: assert property (param_load |-> $past(latch_init))
    else $error("param load without latch init");
  a_irq_after_param: assert property ($rose(rx_irq_enable) |-> $past(param_load) && tx_irq_enable)
    else $error("irq enable out of order");
  a_bg_lamps_off: assert property ($rose(background_run) |-> !protect_fail_lamp && !transmit_activity_lamp)
    else $error("lamp lit at background start");
  a_bg_irqs_on: assert property (background_run |-> rx_irq_enable && tx_irq_enable)
    else $error("background without irqs");
  a_rx_lamp_off: assert property (diag_req |-> !receive_activity_lamp)
    else $error("receive lamp lit during checks");
  a_diag_one_shot: assert property (diag_req |=> !diag_req)
    else $error("check request too long");
  a_msg_held: assert property (ipb_tx.valid && !ipb_tx_ack |=> $stable(ipb_tx))
    else $error("message changed before ack");
  a_tx_lamp_late: assert property ($fell(transmit_activity_lamp) |-> tx_irq_enable)
    else $error("transmit lamp off before irqs");
endmodule
bind edg_seq edg_seq_sva chk (.*);
`default_nettype wire

// File: verification/edg_scb_model.sv
// station control board model: acks messages, answers checks
`timescale 1ns/1ps
`default_nettype none
module edg_scb_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // message link
  input wire edg_pkg::edg_msg_type ipb_tx,
  output edg_pkg::edg_msg_type ipb_rx,
  output logic ipb_tx_ack,
  input wire logic [3:0] send_kind,
  // check engine
  input wire logic diag_req,
  output logic diag_done,
  output logic diag_pass
);
  // idle data toggles so a stale byte is never mistaken for a message
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ipb_rx <= '0;
      ipb_tx_ack <= 1'b0;
      diag_done <= 1'b0;
      diag_pass <= 1'b0;
    end else begin
      ipb_tx_ack <= ipb_tx.valid && !ipb_tx_ack;
      diag_done <= diag_req;
      diag_pass <= diag_req;
      ipb_rx.valid <= 1'b0;
      ipb_rx.data <= ~ipb_rx.data;
      if (ipb_tx.valid && ipb_tx_ack && ipb_tx.kind == edg_pkg::MSG_CHECK) begin
        ipb_rx <= {1'b1, edg_pkg::MSG_CHECK_REPLY, edg_pkg::CHECK_ANSWER};
      end else if (send_kind != 4'h0) begin
        ipb_rx <= {1'b1, send_kind, 8'h00};
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/edg_seq_tb.sv
// self-checking bench for the diagnostic sequencer
`timescale 1ns/1ps
`default_nettype none
module edg_seq_tb;
  logic clk_sys = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic s_axi_arvalid = 0, s_axi_rready = 1, access_disable_pin = 0, tone_detect_pin = 0, station_reset_pin = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, d0;
  logic [3:0] s_axi_wstrb = 4'hf, send_kind = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ipb_tx_ack, diag_req;
  logic diag_done, diag_pass, receive_activity_lamp, transmit_activity_lamp, protect_fail_lamp, nvm_update_enable;
  logic latch_init, param_load, rx_irq_enable, tx_irq_enable, background_run;
  logic [1:0] s_axi_bresp, s_axi_rresp, diag_sel, r;
  edg_pkg::edg_msg_type ipb_rx, ipb_tx;
  edg_pkg::edg_aud_type aud_ctrl;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  edg_seq #(.TICK_CYCLES(4)) dut (.*);
  edg_scb_model scb (.*);
  always #12.5 clk_sys = ~clk_sys;
  // audio board that behaves: tone only where a path is opened
  always @(posedge clk_sys) tone_detect_pin <= aud_ctrl.alert_tone_en | aud_ctrl.mod_tone_en & aud_ctrl.mod_tone_gate
    | aud_ctrl.end_of_message_tone & aud_ctrl.ciphered_audio_gate;
  // hang guard, well above the timeout run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    do @(posedge clk_sys); while (s_axi_awready !== 1);
    s_axi_awvalid <= 0; s_axi_wvalid <= 0;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1;
    do @(posedge clk_sys); while (s_axi_arready !== 1);
    s_axi_arvalid <= 0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1);
    d = s_axi_rdata; r = s_axi_rresp;
  endtask
  task automatic snd(input logic [3:0] k);
    send_kind <= k;
    @(posedge clk_sys);
    send_kind <= 0;
  endtask
  task automatic stn_reset();
    station_reset_pin <= 1; repeat (5) @(posedge clk_sys);
    station_reset_pin <= 0; repeat (10) @(posedge clk_sys);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    rd(8'h0c); chk(d, 32'h0000_0001);
    rd(8'h20); chk(r, edg_pkg::RESP_SLVERR);
    rd(8'h04); chk(d, 32'h0000_0001);
    // wake run: full checks, then wait for background enable
    wr(8'h00, 32'h0000_0001); snd(edg_pkg::MSG_WAKE);
    repeat (3) @(posedge clk_sys);
    while (transmit_activity_lamp !== 0) @(posedge clk_sys);
    repeat (50) @(posedge clk_sys); chk(background_run, 0);
    chk(rx_irq_enable, 1);
    snd(edg_pkg::MSG_BG_ENABLE);
    while (background_run !== 1) @(posedge clk_sys);
    chk(protect_fail_lamp, 0);
    chk(receive_activity_lamp, 0);
    rd(8'h04); chk(d[15], 1);
    // shut-up latches and holds until the station reset
    stn_reset(); access_disable_pin <= 1; wr(8'h00, 32'h0000_0001);
    snd(edg_pkg::MSG_SHUTUP); access_disable_pin <= 0; repeat (20) @(posedge clk_sys);
    rd(8'h04); chk(d & 32'h0001_ffff, 32'h0001_0002);
    stn_reset(); rd(8'h04); chk(d & 32'h0001_ffff, 32'h0000_0001);
    // no wake: timer pauses under access disable, then times out
    wr(8'h00, 32'h0000_0001); repeat (200) @(posedge clk_sys);
    chk(nvm_update_enable, 1);
    access_disable_pin <= 1; repeat (20) @(posedge clk_sys);
    rd(8'h10); d0 = d; repeat (100) @(posedge clk_sys);
    rd(8'h10); chk(d, d0);
    access_disable_pin <= 0; repeat (39000) @(posedge clk_sys);
    chk(background_run, 0);
    while (background_run !== 1) @(posedge clk_sys);
    chk(protect_fail_lamp, 0);
    rd(8'h08); chk(d & 32'h00ff_ffff, 32'h0001_0001);
    wrap_up();
  end
endmodule
`default_nettype wire
